// file: hdl/imwc_pkg.sv
// ==========================================================
// Shared constants for the idle mode wake controller
package imwc_pkg;
	// Register byte offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_WDT    = 4'h8;
	// Control register fields
	localparam int F_IDLE  = 0;       // idle_enable
	localparam int F_CSEL  = 1;       // clock_select, two bits
	localparam int F_FREQ  = 4;       // internal_freq_select, three bits
	localparam int F_ISRC  = 7;       // internal_source_select
	localparam int F_SECEN = 8;       // secondary_osc_enable
	localparam int F_GIE   = 9;       // global_irq_enable
	// Status register fields
	localparam int F_PRIF  = 0;       // primary_ready_flag
	localparam int F_INTF  = 1;       // internal_stable_flag
	localparam int F_SECF  = 2;       // secondary_clock_running
	localparam int F_STATE = 4;       // controller state, three bits
	// Clock source codes
	localparam logic [1:0] SRC_PRI = 2'h0;
	localparam logic [1:0] SRC_SEC = 2'h1;
	localparam logic [1:0] SRC_INT = 2'h2;
	// Timing, 100 MHz reference
	localparam int CLK_PERIOD_NS  = 10;
	localparam int CPU_READY_NS   = 100;   // cpu_ready_delay
	localparam int STAB_NS        = 1000;  // internal stabilization interval
	localparam int CPU_READY_CYC  = (CPU_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STAB_CYC       = (STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDT_PERIOD_CYC = 40000; // watchdog time-out period
	localparam int CNT_W          = 16;
	// Controller states
	typedef enum logic [2:0] {
		ST_STARTUP,
		ST_RUN,
		ST_IDLE,
		ST_SLEEP,
		ST_WAKE
	} imwc_state_t;
endpackage : imwc_pkg

// file: hdl/imwc_ctrl.sv
`timescale 1ns/1ns
// Contract
// R1 - Idle sleep stops CPU, peripherals keep clock
// R2 - Idle keeps RC for watchdog, secondary if enabled
// R3 - Idle exits only by interrupt, watchdog, reset
// R4 - Wake waits ready delay, resumes matching run
// R5 - Wake leaves idle enable and select untouched
// R6 - Watchdog in idle or sleep wakes, no reset
// R7 - Primary idle keeps primary clock and flag
// R8 - Firmware sets idle, clears select, then sleeps
// R9 - Secondary idle stops primary, updates both flags
// R10 - Secondary idle without enable: sleep ignored
// R11 - Peripheral clocks wait for secondary oscillation
// R12 - Internal idle: upper select bit, primary off
// R13 - Fast internal output enabled, flag after stabilization
// R14 - Stable flag kept; all zero keeps it clear
// R15 - Internal idle keeps RC for watchdog or monitor
// R16 - Enabled interrupt flag starts the exit
// R17 - Interrupt wake branches only with global enable
// R18 - Execution resumes right after ready delay
// R19 - Watchdog while running gives watchdog reset
// R20 - Watchdog counter cleared by listed events
// R21 - Reset exit waits primary ready, sets flag
// R22 - Two-speed start runs internal until primary ready
// R23 - Full sleep stops oscillator, clears all flags; on an internal source with freq or isrc set, fast_on and int_f return
// R24 - Ready and stabilization delays are parameter counters
module imwc_ctrl #(
	parameter int IRQ_N         = 8,                       // Interrupt sources
	parameter int CPU_READY_CYC = imwc_pkg::CPU_READY_CYC, // CPU ready delay
	parameter int STAB_CYC      = imwc_pkg::STAB_CYC,      // Fast oscillator settling
	parameter int WDT_CYC       = imwc_pkg::WDT_PERIOD_CYC // Watchdog period
) (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// Avalon-MM slave
	input  wire logic [3:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	input  wire logic [3:0]         avs_byteenable,
	output logic [31:0]             avs_readdata,
	output logic                    avs_waitrequest,
	// CPU core side
	input  wire logic               sleep_cmd,
	input  wire logic               watchdog_clear_cmd,
	input  wire logic [IRQ_N-1:0]   irq_flag,
	input  wire logic [IRQ_N-1:0]   irq_enable,
	// Configuration straps
	input  wire logic               wdt_en,
	input  wire logic               fail_safe_en,
	input  wire logic               two_speed_en,
	input  wire logic               primary_is_internal,
	// Oscillator pins, asynchronous
	input  wire logic               primary_osc_ready,
	input  wire logic               secondary_osc_running,
	input  wire logic               clock_lost,
	// Clock gating, oscillator control, vector branch and watchdog reset
	output logic                    cpu_clk_en,
	output logic                    periph_clk_en,
	output logic [1:0]              periph_clk_sel,
	output logic                    primary_osc_en,
	output logic                    secondary_osc_keep,
	output logic                    low_power_rc_en,
	output logic                    fast_internal_osc_en,
	output logic                    irq_vector_branch,
	output logic                    wdt_reset
);
	import imwc_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		imwc_state_t      st;         // Controller state
		logic             busy;       // Bus waitrequest level
		logic [31:0]      rdata;      // Bus read data
		logic             idle_en;    // idle_enable
		logic [1:0]       csel;       // clock_select
		logic [2:0]       freq;       // internal_freq_select
		logic             isrc;       // internal_source_select
		logic             sec_en;     // secondary_osc_enable
		logic             gie;        // global_irq_enable
		logic             pri_f;      // primary_ready_flag
		logic             int_f;      // internal_stable_flag
		logic             sec_f;      // secondary_clock_running
		logic [1:0]       src;        // Source in use
		logic             irqw;       // Wake came from an interrupt
		logic [CNT_W-1:0] cnt;        // Ready delay counter
		logic [CNT_W-1:0] stab;       // Stabilization counter
		logic [CNT_W-1:0] wdt;        // Watchdog counter
		logic             pr1, pr2;   // Primary ready synchroniser
		logic             sr1, sr2;   // Secondary running synchroniser
		logic             cl1, cl2;   // Clock loss synchroniser
		logic             cpu_en;     // CPU clock gate
		logic             per_en;     // Peripheral clock gate
		logic             pri_on;     // Primary oscillator enable
		logic             fast_on;    // Fast internal output enable
		logic             lprc_on;    // Low power RC enable
		logic             branch;     // Vector branch pulse
		logic             wrst;       // Watchdog reset pulse
	} imwc_regs_t;

	imwc_regs_t q, d;      // Registered state and its next value
	logic       irq_hit;   // Enabled interrupt pending
	logic       wdt_fire;  // Watchdog time-out this cycle
	logic       src_rdy;   // Selected source able to clock
	logic       wr_ok;     // Write accepted this edge
	logic       sleep_ok;  // Sleep command may be honoured
	logic [1:0] tgt;       // Source decoded from clock_select

	// ==========================================================
	// Next state
	always_comb begin
		d        = q;
		d.branch = 1'b0;
		d.wrst   = 1'b0;
		// Pins pass two flops; first stage feeds only the second
		d.pr1 = primary_osc_ready;
		d.pr2 = q.pr1;
		d.sr1 = secondary_osc_running;
		d.sr2 = q.sr1;
		d.cl1 = clock_lost;
		d.cl2 = q.cl1;
		irq_hit  = |(irq_flag & irq_enable);                         // R16
		wdt_fire = wdt_en && (q.wdt == CNT_W'(WDT_CYC - 1));
		// Lower select bit ignored once upper bit set
		tgt = q.csel[1] ? SRC_INT : q.csel;                          // R12
		src_rdy = (q.src == SRC_PRI) ? (q.pr2 && q.pri_on)
			: (q.src == SRC_SEC) ? q.sr2 : 1'b1;
		// Bus: one wait cycle, then a single answer cycle
		d.busy = !((avs_read || avs_write) && q.busy);
		wr_ok  = avs_write && !q.busy;
		if ((avs_read || avs_write) && q.busy) begin
			case (avs_address)
				REG_CTRL: d.rdata = 32'({q.gie, q.sec_en, q.isrc, q.freq, 1'b0, q.csel,
					q.idle_en});
				REG_STATUS: d.rdata = 32'({q.st, 1'b0, q.sec_f, q.int_f, q.pri_f});
				REG_WDT: d.rdata = 32'(q.wdt);
				default: d.rdata = 32'h0;  // Unmapped reads as zero
			endcase
		end
		if (wr_ok && avs_address == REG_CTRL && avs_byteenable[0]) begin
			d.idle_en = avs_writedata[F_IDLE];
			d.csel    = avs_writedata[F_CSEL +: 2];
			d.freq    = avs_writedata[F_FREQ +: 3];
			d.isrc    = avs_writedata[F_ISRC];
		end
		if (wr_ok && avs_address == REG_CTRL && avs_byteenable[1]) begin
			d.sec_en = avs_writedata[F_SECEN];
			d.gie    = avs_writedata[F_GIE];
		end
		// Watchdog counter and its clear events
		if (sleep_cmd || watchdog_clear_cmd || (q.cl2 && fail_safe_en)
			|| (wr_ok && avs_address == REG_CTRL && avs_byteenable[0]
			&& q.src == SRC_INT && d.freq != q.freq) || wdt_fire) begin
			d.wdt = '0;                                              // R20
		end else if (wdt_en) begin
			d.wdt = q.wdt + CNT_W'(1);
		end
		// Fast internal output and its settling
		d.fast_on = (q.freq != 3'h0 || q.isrc)
			&& (q.src == SRC_INT || primary_is_internal);            // R13
		if (!q.fast_on) begin
			d.stab = '0;
			if (!primary_is_internal) begin
				d.int_f = 1'b0;                                      // R14
			end
		end else if (!q.int_f) begin
			// Peripheral clocks keep running during this wait, except in full sleep where per_en stays low
			if (q.stab == CNT_W'(STAB_CYC - 1)) begin
				d.int_f = 1'b1;                                      // R13 R24
			end else begin
				d.stab = q.stab + CNT_W'(1);
			end
		end
		// Low power RC for watchdog and clock monitor
		d.lprc_on = wdt_en || fail_safe_en || q.src == SRC_INT;      // R2 R15
		// Primary flag follows its running oscillator
		if (q.src == SRC_PRI && q.pri_on && q.pr2 && q.st != ST_SLEEP) begin
			d.pri_f = 1'b1;                                          // R7
		end
		sleep_ok = sleep_cmd && (q.st == ST_RUN
			|| (q.st == ST_STARTUP && (two_speed_en || fail_safe_en)));
		case (q.st)
			// Hold after reset until primary is ready
			ST_STARTUP: begin
				d.cpu_en = two_speed_en || fail_safe_en;             // R22
				d.per_en = d.cpu_en;
				d.src    = d.cpu_en ? SRC_INT : SRC_PRI;
				if (q.pr2) begin
					d.st     = ST_RUN;                               // R21
					d.src    = SRC_PRI;
					d.cpu_en = 1'b1;
					d.per_en = 1'b1;
					d.pri_f  = !primary_is_internal;
					d.int_f  = primary_is_internal || q.int_f;
				end
			end
			// Executing code
			ST_RUN: begin
				if (wdt_fire) begin
					d.wrst = 1'b1;                                   // R19
				end
				if (q.src == SRC_SEC) begin
					d.sec_f = 1'b1;
				end
			end
			// Idle or sleep: wait for a legal wake
			ST_IDLE, ST_SLEEP: begin
				if (q.st == ST_IDLE) begin
					d.per_en = src_rdy;                              // R7 R11
				end
				if (irq_hit || wdt_fire) begin                       // R3 R6
					// Wake targets the selected run mode
					d.st   = ST_WAKE;
					d.irqw = irq_hit;
					d.cnt  = '0;
					d.src  = tgt;                                    // R4 R6
					d.pri_on = q.pri_on || tgt == SRC_PRI;
				end
			end
			// CPU ready delay, then resume
			ST_WAKE: begin
				d.per_en = src_rdy;
				if (q.cnt != CNT_W'(CPU_READY_CYC - 1)) begin
					d.cnt = q.cnt + CNT_W'(1);                       // R24
				end else if (src_rdy) begin
					d.st     = ST_RUN;                               // R18
					d.cpu_en = 1'b1;
					d.branch = q.irqw && q.gie;                      // R17
					d.sec_f  = q.src == SRC_SEC;
				end
			end
			default: d.st = ST_STARTUP;
		endcase
		// Sleep command entry; control bits never touched here
		if (sleep_ok && q.idle_en) begin                             // R5
			if (!(tgt == SRC_SEC && !q.sec_en)) begin                // R10
				d.st     = ST_IDLE;                                  // R1
				d.cpu_en = 1'b0;
				d.src    = tgt;
				// Peripherals wait for a source that is not yet clocking
				d.per_en = (tgt == SRC_SEC) ? q.sr2
					: (tgt == SRC_PRI) ? (q.pr2 && q.pri_on) : 1'b1;
				if (tgt != SRC_PRI) begin
					d.pri_on = 1'b0;                                 // R9 R12 R22
					d.pri_f  = 1'b0;
				end else begin
					d.pri_on = 1'b1;                                 // R7
				end
				d.sec_f = tgt == SRC_SEC;                            // R9
			end
		end else if (sleep_ok) begin
			d.st      = ST_SLEEP;                                    // R23
			d.cpu_en  = 1'b0;
			d.per_en  = 1'b0;
			d.pri_on  = 1'b0;
			d.pri_f   = 1'b0;
			d.int_f   = 1'b0;
			d.sec_f   = 1'b0;
			d.fast_on = 1'b0;
		end
	end

	// ==========================================================
	// Register everything; synchronous reset to constants
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q        <= '0;
			q.st     <= ST_STARTUP;
			q.busy   <= 1'b1;
			q.pri_on <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs straight from flops
	assign avs_readdata         = q.rdata;
	assign avs_waitrequest      = q.busy;
	assign cpu_clk_en           = q.cpu_en;
	assign periph_clk_en        = q.per_en;
	assign periph_clk_sel       = q.src;
	assign primary_osc_en       = q.pri_on;
	assign secondary_osc_keep   = q.sec_en;   // R2
	assign low_power_rc_en      = q.lprc_on;
	assign fast_internal_osc_en = q.fast_on;
	assign irq_vector_branch    = q.branch;
	assign wdt_reset            = q.wrst;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_idle_req;
		sleep_cmd && q.st == ST_RUN && q.idle_en;
	endsequence
	sequence s_wake_done;
		q.st == ST_WAKE && q.cnt == CNT_W'(CPU_READY_CYC - 1) && src_rdy;
	endsequence

	property p_idle_entry;
		s_idle_req and !(tgt == SRC_SEC && !q.sec_en) |=> q.st == ST_IDLE && !cpu_clk_en;
	endproperty
	a_idle_entry: assert property (p_idle_entry) else $error("idle entry"); // R1
	property p_sec_refuse;
		s_idle_req and (tgt == SRC_SEC && !q.sec_en) |=> q.st == ST_RUN && cpu_clk_en;
	endproperty
	a_sec_refuse: assert property (p_sec_refuse) else $error("sleep not ignored"); // R10
	property p_sec_entry;
		s_idle_req and (tgt == SRC_SEC && q.sec_en)
			|=> q.sec_f && !q.pri_f && !primary_osc_en;
	endproperty
	a_sec_entry: assert property (p_sec_entry) else $error("secondary flags"); // R9
	property p_stay_idle;
		q.st == ST_IDLE && !irq_hit && !wdt_fire |=> q.st == ST_IDLE;
	endproperty
	a_stay_idle: assert property (p_stay_idle) else $error("spurious wake"); // R3
	property p_resume;
		s_wake_done |=> cpu_clk_en && q.st == ST_RUN ##1 (cpu_clk_en || $past(sleep_cmd));
	endproperty
	a_resume: assert property (p_resume) else $error("late resume"); // R18
	property p_ready_delay;
		$rose(cpu_clk_en) && $past(q.st) == ST_WAKE
			|-> $past(q.cnt) == CNT_W'(CPU_READY_CYC - 1);
	endproperty
	a_ready_delay: assert property (p_ready_delay) else $error("early resume"); // R4
	property p_full_sleep;
		sleep_cmd && q.st == ST_RUN && !q.idle_en
			|=> q.st == ST_SLEEP && !q.pri_f && !q.int_f && !q.sec_f && !periph_clk_en;
	endproperty
	a_full_sleep: assert property (p_full_sleep) else $error("sleep flags"); // R23
	property p_wdt_run;
		q.st == ST_RUN && wdt_fire |=> wdt_reset ##1 !wdt_reset;
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("no watchdog reset"); // R19
	property p_wdt_wake;
		(q.st == ST_IDLE || q.st == ST_SLEEP) && wdt_fire
			|=> q.st == ST_WAKE && !wdt_reset;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake"); // R6
	property p_wdt_clear;
		watchdog_clear_cmd |=> q.wdt == '0;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared"); // R20
	property p_branch;
		irq_vector_branch |-> q.gie && $past(q.irqw);
	endproperty
	a_branch: assert property (p_branch) else $error("bad branch"); // R17
	property p_sec_hold;
		q.st == ST_IDLE && q.src == SRC_SEC && !q.sr2 && !sleep_cmd |=> !periph_clk_en;
	endproperty
	a_sec_hold: assert property (p_sec_hold) else $error("clock before osc"); // R11
endmodule : imwc_ctrl

// file: tb/imwc_osc_model.sv
`timescale 1ns/1ns
// ==========================================
// Oscillator sources facing the controller
module imwc_osc_model #(
	parameter int PRI_START = 6,  // Primary warm-up cycles
	parameter int SEC_START = 20  // Secondary start-up cycles
) (
	input  wire logic ref_clk,
	input  wire logic primary_osc_en,
	input  wire logic secondary_osc_keep,
	output logic      primary_osc_ready,
	output logic      secondary_osc_running
);
	int pri_cnt = 0; // Warm-up progress
	int sec_cnt = 0; // Start-up progress
	// Counters restart whenever an oscillator is switched off
	always @(posedge ref_clk) begin
		pri_cnt <= primary_osc_en ? pri_cnt + int'(pri_cnt < PRI_START) : 0;
		sec_cnt <= secondary_osc_keep ? sec_cnt + int'(sec_cnt < SEC_START) : 0;
	end
	// Slow secondary start lets the clock hold-off be seen
	assign primary_osc_ready     = (pri_cnt >= PRI_START);
	assign secondary_osc_running = (sec_cnt >= SEC_START);
endmodule : imwc_osc_model

// file: tb/test_idle_mode_wake_controller.sv
`timescale 1ns/1ns
module test_idle_mode_wake_controller;
	import imwc_pkg::*;
	localparam int CRC = 4;                 // Short ready delay
	logic        ref_clk = 0, rst = 1;     // Clock and reset
	logic [3:0]  avs_address = 4'h0;       // Bus request
	logic        avs_read = 0, avs_write = 0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic        avs_waitrequest, sleep_cmd = 0, watchdog_clear_cmd = 0, wdt_en = 0;
	logic        fail_safe_en = 0, two_speed_en = 0, clock_lost = 0; // Straps, loss pin
	logic [3:0]  avs_byteenable = 4'hF;    // Lane enables
	logic [7:0]  irq_flag = 8'h00, irq_enable = 8'h00;
	logic        primary_osc_ready, secondary_osc_running, cpu_clk_en, periph_clk_en;
	logic        primary_osc_en, secondary_osc_keep, low_power_rc_en, fast_internal_osc_en;
	logic        irq_vector_branch, wdt_reset;
	logic [1:0]  periph_clk_sel;
	int          num_errors = 0, n_tests = 0, cyc, wdt_hits = 0;
	// ==========================================
	// Clock, design and oscillators
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	imwc_ctrl #(.IRQ_N(8), .CPU_READY_CYC(CRC), .STAB_CYC(4), .WDT_CYC(50)) u_imwc_ctrl (
		.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_cmd(sleep_cmd),
		.watchdog_clear_cmd(watchdog_clear_cmd), .irq_flag(irq_flag), .irq_enable(irq_enable),
		.wdt_en(wdt_en), .fail_safe_en(fail_safe_en), .two_speed_en(two_speed_en),
		.primary_is_internal(1'b0),
		.primary_osc_ready(primary_osc_ready), .secondary_osc_running(secondary_osc_running),
		.clock_lost(clock_lost), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.periph_clk_sel(periph_clk_sel), .primary_osc_en(primary_osc_en),
		.secondary_osc_keep(secondary_osc_keep), .low_power_rc_en(low_power_rc_en),
		.fast_internal_osc_en(fast_internal_osc_en), .irq_vector_branch(irq_vector_branch),
		.wdt_reset(wdt_reset));
	imwc_osc_model u_imwc_osc_model (.ref_clk(ref_clk), .primary_osc_en(primary_osc_en),
		.secondary_osc_keep(secondary_osc_keep), .primary_osc_ready(primary_osc_ready),
		.secondary_osc_running(secondary_osc_running));
	// Count every watchdog reset pulse
	always @(posedge ref_clk) begin
		if (wdt_reset === 1'b1) wdt_hits++;
	end
	// ==========================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk
	// Request held until waitrequest seen low at an edge
	task automatic bus_rd(input logic [3:0] a);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		@(posedge ref_clk iff avs_waitrequest === 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask : bus_rd
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		@(posedge ref_clk iff avs_waitrequest === 1'b0);
		avs_write <= 1'b0;
	endtask : bus_wr
	// One-cycle sleep instruction, then let the state settle
	task automatic do_sleep;
		@(posedge ref_clk);
		sleep_cmd <= 1'b1;
		@(posedge ref_clk);
		sleep_cmd <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask : do_sleep
	// Bounded wait for CPU clock, cycles counted
	task automatic wait_cpu;
		cyc = 0;
		while (cpu_clk_en !== 1'b1 && cyc < 300) begin
			@(posedge ref_clk);
			cyc++;
		end
		// A wait that runs out counts as a mismatch
		chk(cpu_clk_en, 1'b1, "cpu clock back");
	endtask : wait_cpu
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	// Hang guard, far beyond the planned run
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		close_out();
	end
	// ==========================================
	// Scenarios
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		wait_cpu();
		bus_rd(REG_STATUS); chk(rd, 32'h11, "reset exit");
		bus_rd(REG_CTRL); chk(rd, 32'h0, "ctrl reset");
		bus_rd(4'hC); chk(rd, 32'h0, "unmapped");
		bus_wr(REG_STATUS, 32'hFFFFFFFF); bus_rd(REG_STATUS); chk(rd, 32'h11, "status ro");
		// Watchdog while running: reset pulse, no sleep
		wdt_en <= 1'b1;
		cyc = 0;
		while (wdt_reset !== 1'b1 && cyc < 200) begin
			@(posedge ref_clk);
			cyc++;
		end
		chk(wdt_reset, 1'b1, "run timeout");
		@(posedge ref_clk); watchdog_clear_cmd <= 1'b1;
		@(posedge ref_clk); watchdog_clear_cmd <= 1'b0;
		bus_rd(REG_WDT); chk(rd < 8, 1'b1, "wdt cleared");
		wdt_en <= 1'b0;
		// Primary idle, disabled irq ignored, enabled irq wakes
		bus_wr(REG_CTRL, 32'h201); do_sleep();
		chk({cpu_clk_en, periph_clk_en, periph_clk_sel}, 4'b0100, "primary_idle");
		chk(primary_osc_en, 1'b1, "pri kept");
		bus_rd(REG_STATUS); chk(rd, 32'h21, "pri flags");
		irq_flag <= 8'h04; repeat (20) @(posedge ref_clk);
		chk(cpu_clk_en, 1'b0, "no stray wake");
		irq_enable <= 8'h04; wait_cpu();
		// Wake one edge after enable, rise seen one edge after launch
		chk(cyc, CRC + 2, "ready delay");
		chk(irq_vector_branch, 1'b1, "branch gie");
		irq_flag <= 8'h00; irq_enable <= 8'h00;
		bus_rd(REG_CTRL); chk(rd, 32'h201, "ctrl kept");
		bus_rd(REG_STATUS); chk(rd, 32'h11, "primary_run");
		// Secondary idle without enable is ignored
		bus_wr(REG_CTRL, 32'h003); do_sleep();
		chk(cpu_clk_en, 1'b1, "sec refused");
		// Secondary idle before the oscillator runs
		bus_wr(REG_CTRL, 32'h103); do_sleep();
		chk({cpu_clk_en, periph_clk_en}, 2'b00, "sec hold");
		cyc = 0;
		while (secondary_osc_running !== 1'b1 && cyc < 100) begin
			@(posedge ref_clk);
			cyc++;
		end
		repeat (4) @(posedge ref_clk);
		chk({periph_clk_en, periph_clk_sel, primary_osc_en}, 4'b1010, "secondary_idle");
		chk(secondary_osc_keep, 1'b1, "sec kept");
		bus_rd(REG_STATUS); chk(rd, 32'h24, "sec flags");
		irq_flag <= 8'h01; irq_enable <= 8'h01; wait_cpu();
		chk({irq_vector_branch, periph_clk_sel}, 3'b001, "sec wake");
		irq_flag <= 8'h00; irq_enable <= 8'h00;
		// Internal idle, woken by the watchdog
		wdt_en <= 1'b1;
		bus_wr(REG_CTRL, 32'h037); cyc = wdt_hits; do_sleep();
		chk({periph_clk_sel, primary_osc_en, fast_internal_osc_en}, 4'b1001, "int idle");
		chk(low_power_rc_en, 1'b1, "rc kept");
		repeat (8) @(posedge ref_clk);
		bus_rd(REG_STATUS); chk(rd, 32'h22, "int stable");
		rd = cyc; wait_cpu();
		chk(cpu_clk_en, 1'b1, "wdt wake");
		chk(wdt_hits, rd, "no wdt reset");
		chk(periph_clk_sel, 2'b10, "int run");
		wdt_en <= 1'b0;
		// Primary idle from internal run: idle kept set, select cleared, then sleep
		bus_wr(REG_CTRL, 32'h231); do_sleep();
		chk({periph_clk_sel, primary_osc_en}, 3'b001, "pri restart");
		irq_flag <= 8'h02; irq_enable <= 8'h02; wait_cpu();
		chk({periph_clk_en, periph_clk_sel, irq_vector_branch}, 4'b1001, "pri wake");
		irq_flag <= 8'h00; irq_enable <= 8'h00;
		// Full sleep clears every source flag
		bus_wr(REG_CTRL, 32'h200); do_sleep();
		chk({cpu_clk_en, primary_osc_en}, 2'b00, "sleep off");
		bus_rd(REG_STATUS); chk(rd, 32'h30, "sleep flags");
		irq_flag <= 8'h80; irq_enable <= 8'h80; wait_cpu();
		chk(cpu_clk_en, 1'b1, "sleep wake");
		irq_flag <= 8'h00; irq_enable <= 8'h00;
		// Lane 1 untouched when only lane 0 is enabled
		avs_byteenable <= 4'h1; bus_wr(REG_CTRL, 32'h3F6);
		avs_byteenable <= 4'hF; bus_rd(REG_CTRL); chk(rd, 32'h2F6, "lane mask");
		// Mid-run reset with two-speed start: internal clock first
		two_speed_en <= 1'b1; fail_safe_en <= 1'b1; rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({cpu_clk_en, periph_clk_sel}, 3'b110, "two-speed start");
		repeat (4) @(posedge ref_clk);
		chk(periph_clk_sel, 2'b00, "primary takes over");
		bus_rd(REG_STATUS); chk(rd, 32'h11, "reset flags");
		// Clock loss with the monitor on holds the watchdog cleared
		wdt_en <= 1'b1; repeat (20) @(posedge ref_clk);
		clock_lost <= 1'b1; repeat (4) @(posedge ref_clk);
		bus_rd(REG_WDT); chk(rd, 32'h0, "loss clears wdt");
		clock_lost <= 1'b0; wdt_en <= 1'b0;
		close_out();
	end
endmodule : test_idle_mode_wake_controller
